/* core/smrc_core.sv */
// stop mode sequencer, standby control register and reset start logic
// Operation
// - write 02H sets stop request, enters stop
// - leave stop only by interrupt edge or reset
// - reset clears standby control to zero
// - stop request bit self clears on exit
// - stop halts oscillator, clock, cpu, peripherals
// - io lines hold pre-stop state
// - internal state and ram kept during stop
// - crystal input grounded while stopped
// - selected interrupt edge restarts the oscillator
// - count starts after interrupt line returns
// - system clock resumes on counter overflow
// - interrupt exit continues at interrupt routine
// - reset falling edge resets, restarts oscillator
// - reset exit skips stabilization wait
// - reset exit keeps memory and registers
// - program counter loaded from two vector bytes
// - timers read zero from 17th clock
// - first port floats, port6 low nibble low
`timescale 1ns/100ps
`include "smrc_map.svh"
module smrc_core
(
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// register access from the cpu
	input wire smrc_pkg::smrc_req_s req_in,
	output logic [7:0] rdata_out,
	// interrupt pin and its edge select (1 = rising)
	input wire logic nmi_in,
	input wire logic edge_select_in,
	// vector fetch data from program memory
	input wire logic [7:0] vec_data_in,
	output logic [15:0] vec_addr_out,
	output logic vec_rd_out,
	// program counter load
	output logic [15:0] program_counter_out,
	output logic pc_load_out,
	output logic nmi_vector_out,
	// chip gating
	output smrc_pkg::smrc_gate_s gate_out,
	output logic in_stop_out,
	output logic retain_out,
	// reset side states of ports and timers
	output logic [7:0] port0_oe_n_out,
	output logic [3:0] port6_low_out,
	output logic [3:0] port6_low_oe_n_out,
	output logic timer_zero_out
);
	import smrc_pkg::*;

	smrc_state_e state_q; // sequencer state
	smrc_state_e state_d;
	logic [7:0] stby_q; // standby control register
	logic [7:0] stby_d;
	logic [15:0] pc_q; // assembled vector
	logic [15:0] pc_d;
	logic load_q; // one-cycle program counter load
	logic load_d;
	logic nmi_q; // interrupt pin, previous sample
	logic nmi_d;
	logic via_nmi_q; // exit came through the interrupt
	logic via_nmi_d;
	logic [4:0] tmr_q; // clocks since reset release
	logic [4:0] tmr_d;
	logic [7:0] rdata_q; // registered read data
	logic [7:0] rdata_d;
	logic [7:0] p0_oe_n_q; // first port output enables, low drives
	logic [7:0] p0_oe_n_d;
	logic stab_ovf; // counter wrapped
	logic nmi_edge; // selected edge seen
	logic nmi_idle; // pin back at idle level
	logic osc_on; // oscillator running

	// true when the access hits the standby control register
	function automatic logic hit_stby(input logic [15:0] a);
		hit_stby = (a == `SMRC_STBY_ADDR);
	endfunction

	// edge detect on the pin, polarity from the edge select
	always_comb
	begin
		nmi_d = nmi_in;
		nmi_edge = edge_select_in ? (nmi_in && !nmi_q) : (!nmi_in && nmi_q);
		nmi_idle = edge_select_in ? !nmi_in : nmi_in;
	end

	// oscillator runs in every state but the stopped one
	assign osc_on = (state_q != SMRC_STOPPED);

	// stabilization counter runs on the restarted oscillator only
	smrc_stab_counter u_stab
	(
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.clear_in(state_q == SMRC_RUN && state_d == SMRC_STOPPED),
		.count_in(state_q == SMRC_STAB),
		.overflow_out(stab_ovf)
	);

	// decodes shared by the register and sequencer groups
	function automatic logic is_running(input smrc_state_e s);
		is_running = (s == SMRC_RUN);
	endfunction

	logic stby_write; // cpu write to the standby control register
	logic stby_read; // cpu read of any address
	logic wake_done; // last stabilization cycle of an interrupt exit

	// the cpu is halted outside the run state, so requests then are ignored
	assign stby_write = is_running(state_q) && req_in.wr && hit_stby(req_in.addr);
	assign stby_read = is_running(state_q) && req_in.rd;
	assign wake_done = (state_q == SMRC_STAB) && stab_ovf;

	// sequencer next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			SMRC_RUN:
			begin
				// a write without the stop bit leaves the chip running
				if (stby_write && req_in.wdata[`SMRC_STOP_BIT])
					state_d = SMRC_STOPPED;
			end
			SMRC_STOPPED:
			begin
				// only the interrupt edge leaves; reset is handled asynchronously
				if (nmi_edge)
					state_d = SMRC_EDGE_WAIT;
			end
			SMRC_EDGE_WAIT:
			begin
				// pulse width must end before the count may begin
				if (nmi_idle)
					state_d = SMRC_STAB;
			end
			SMRC_STAB:
			begin
				// system clock stays off until the counter wraps
				if (wake_done)
					state_d = SMRC_RUN;
			end
			SMRC_VEC_LO:
			begin
				// no wait after reset, fetch starts at once
				state_d = SMRC_VEC_HI;
			end
			SMRC_VEC_HI:
			begin
				// second byte in, the cpu starts on the next edge
				state_d = SMRC_RUN;
			end
			default:
			begin
				// an illegal code recovers through a fresh vector fetch
				state_d = SMRC_VEC_LO;
			end
		endcase
	end

	// sequencer state register; reset forces the vector fetch
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state_q <= SMRC_VEC_LO;
		else
			state_q <= state_d;
	end

	// standby control: cpu write, self clear when the interrupt exit completes
	always_comb
	begin
		stby_d = stby_q;
		if (stby_write)
			stby_d = req_in.wdata & `SMRC_STOP_CMD;
		else if (wake_done)
			stby_d[`SMRC_STOP_BIT] = 1'b0;
	end

	// standby control register; only the stop bit is implemented, others read zero
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			stby_q <= `SMRC_STBY_RESET;
		else
			stby_q <= stby_d;
	end

	// exit cause: set by the interrupt wake, cleared by every reset vector fetch
	always_comb
	begin
		via_nmi_d = via_nmi_q;
		if (wake_done)
			via_nmi_d = 1'b1;
		else if (state_q == SMRC_VEC_HI)
			via_nmi_d = 1'b0;
	end

	// exit cause register, tells the cpu which start routine to take
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			via_nmi_q <= 1'b0;
		else
			via_nmi_q <= via_nmi_d;
	end

	// vector assembly: low byte first, high byte second, then one load pulse
	always_comb
	begin
		pc_d = pc_q;
		load_d = 1'b0;
		if (state_q == SMRC_VEC_LO)
			pc_d[7:0] = vec_data_in;
		else if (state_q == SMRC_VEC_HI)
		begin
			pc_d[15:8] = vec_data_in;
			load_d = 1'b1;
		end
	end

	// vector register and load strobe; the pulse lasts exactly one cycle
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pc_q <= 16'h0000;
			load_q <= 1'b0;
		end
		else
		begin
			pc_q <= pc_d;
			load_q <= load_d;
		end
	end

	// previous pin sample for the edge detector; the pin is taken as synchronous
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			nmi_q <= 1'b0;
		else
			nmi_q <= nmi_d;
	end

	// timer blanking: counts clocks after reset release and then sticks
	always_comb
	begin
		tmr_d = tmr_q;
		if (tmr_q != `SMRC_TMR_BLANK)
			tmr_d = tmr_q + 5'h01;
	end

	// blanking counter; timers outside read zero once it has reached its end
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			tmr_q <= 5'h00;
		else
			tmr_q <= tmr_d;
	end

	// read data: the standby register or zero for any other address
	always_comb
	begin
		rdata_d = rdata_q;
		if (stby_read && hit_stby(req_in.addr))
			rdata_d = stby_q;
		else if (stby_read)
			rdata_d = 8'h00;
	end

	// read data register; holds its value until the next read
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	// first port enables: nothing here turns a driver on, port software does that later
	always_comb
	begin
		p0_oe_n_d = p0_oe_n_q;
	end

	// first port enable register, all drivers off from reset on
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			p0_oe_n_q <= 8'hFF;
		else
			p0_oe_n_q <= p0_oe_n_d;
	end

	// vector addresses are driven during the two fetch states
	assign vec_addr_out = (state_q == SMRC_VEC_HI) ? `SMRC_VEC_HI_ADDR : `SMRC_VEC_LO_ADDR;
	assign vec_rd_out = (state_q == SMRC_VEC_LO) || (state_q == SMRC_VEC_HI);
	assign program_counter_out = pc_q;
	assign pc_load_out = load_q;
	assign nmi_vector_out = via_nmi_q;
	assign rdata_out = rdata_q;

	// clock gating: system clock only when not stopped nor stabilizing
	always_comb
	begin
		gate_out.osc_run = osc_on;
		gate_out.sys_clk_en = (state_q == SMRC_RUN) || vec_rd_out;
		gate_out.cpu_run = (state_q == SMRC_RUN);
		gate_out.periph_run = (state_q == SMRC_RUN);
		gate_out.xtal_ground = (state_q == SMRC_STOPPED);
	end

	assign in_stop_out = (state_q != SMRC_RUN) && !vec_rd_out;
	// ram and register file must not be cleared; io latches freeze with the clock
	assign retain_out = 1'b1;
	assign port0_oe_n_out = p0_oe_n_q;
	assign port6_low_out = `SMRC_P6_LOW;
	assign port6_low_oe_n_out = 4'h0;
	assign timer_zero_out = (tmr_q == `SMRC_TMR_BLANK);
endmodule // smrc_core

/* core/smrc_map.svh */
// offsets, field positions, reset values and timing counts of the stop mode and reset control block
`ifndef SMRC_MAP_SVH
`define SMRC_MAP_SVH
`define SMRC_STBY_ADDR 16'hFFC0
`define SMRC_STBY_RESET 8'h00
`define SMRC_STOP_BIT 1
`define SMRC_STOP_CMD 8'h02
`define SMRC_VEC_LO_ADDR 16'h0000
`define SMRC_VEC_HI_ADDR 16'h0001
`define SMRC_TMR_BLANK 5'h10
`define SMRC_STAB_BITS 16
`define SMRC_P6_LOW 4'h0
`endif

/* core/smrc_pkg.sv */
// types shared by the stop mode and reset control block
package smrc_pkg;
	// sequencer states
	typedef enum logic [2:0]
	{
		SMRC_RUN = 3'b000,
		SMRC_STOPPED = 3'b001,
		SMRC_EDGE_WAIT = 3'b010,
		SMRC_STAB = 3'b011,
		SMRC_VEC_LO = 3'b100,
		SMRC_VEC_HI = 3'b101
	} smrc_state_e;
	// cpu side register read and write request
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} smrc_req_s;
	// gating outputs toward the rest of the chip
	typedef struct packed
	{
		logic osc_run;
		logic sys_clk_en;
		logic cpu_run;
		logic periph_run;
		logic xtal_ground;
	} smrc_gate_s;
endpackage

/* core/smrc_stab_counter.sv */
// oscillation stabilization counter, clocked only by the restarted oscillator enable
`timescale 1ns/100ps
`include "smrc_map.svh"
module smrc_stab_counter
(
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// control
	input wire logic clear_in,
	input wire logic count_in,
	// status
	output logic overflow_out
);
	import smrc_pkg::*;
	logic [`SMRC_STAB_BITS-1:0] cnt_q; // running count
	logic [`SMRC_STAB_BITS-1:0] cnt_d;
	logic ovf_q; // one pulse on wrap
	logic ovf_d;

	// next count: cleared on stop entry, advances only while count_in is set
	always_comb
	begin
		cnt_d = cnt_q;
		ovf_d = 1'b0;
		if (clear_in)
			cnt_d = '0;
		else if (count_in)
		begin
			{ovf_d, cnt_d} = {1'b0, cnt_q} + 17'h00001;
		end
	end

	// register stage
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cnt_q <= '0;
			ovf_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
		end
	end

	assign overflow_out = ovf_q;
endmodule // smrc_stab_counter

/* test/smrc_core_monitor.sv */
// assertion checker for the stop mode and reset control block
`timescale 1ns/100ps
module smrc_core_monitor
(
	// clock, reset, inputs
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire smrc_pkg::smrc_req_s req_in,
	input wire logic nmi_in,
	input wire logic edge_select_in,
	input wire logic [7:0] vec_data_in,
	// outputs
	input wire logic [15:0] vec_addr_out,
	input wire logic vec_rd_out,
	input wire logic [15:0] program_counter_out,
	input wire logic pc_load_out,
	input wire logic nmi_vector_out,
	input wire smrc_pkg::smrc_gate_s gate_out,
	input wire logic in_stop_out,
	input wire logic [7:0] port0_oe_n_out,
	input wire logic [3:0] port6_low_out,
	input wire logic [3:0] port6_low_oe_n_out,
	input wire logic timer_zero_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	logic [4:0] up_q; // edges since release, saturating
	logic [16:0] osc_q; // oscillator cycles inside stop
	// counters kept apart from the design so a stuck wait shows up
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			up_q <= 5'h00;
			osc_q <= 17'h00000;
		end
		else
		begin
			up_q <= up_q + {4'h0, up_q != 5'h1F};
			osc_q <= !in_stop_out ? 17'h00000 : osc_q + {16'h0000, gate_out.osc_run};
		end
	end
	sequence s_fetch;
		vec_rd_out && vec_addr_out == 16'h0000 ##1 vec_rd_out && vec_addr_out == 16'h0001;
	endsequence
	property p_entry;
		req_in.wr && req_in.addr == 16'hFFC0 && req_in.wdata[1] && gate_out.cpu_run |=> in_stop_out && gate_out.xtal_ground;
	endproperty
	property p_halt;
		in_stop_out |-> !gate_out.sys_clk_en && !gate_out.cpu_run && !gate_out.periph_run;
	endproperty
	property p_stay;
		in_stop_out && !gate_out.osc_run && $stable(nmi_in) |=> in_stop_out;
	endproperty
	property p_wake;
		in_stop_out && !gate_out.osc_run && $changed(nmi_in) && nmi_in == edge_select_in |-> ##[1:2] gate_out.osc_run;
	endproperty
	property p_stab;
		$fell(in_stop_out) |-> osc_q >= 17'h10000;
	endproperty
	property p_exit;
		$fell(in_stop_out) |-> ##[0:1] nmi_vector_out;
	endproperty
	property p_vec;
		s_fetch |=> pc_load_out && program_counter_out == {$past(vec_data_in), $past(vec_data_in, 2)};
	endproperty
	property p_timer;
		up_q < 5'd20 |-> timer_zero_out == (up_q >= 5'd16);
	endproperty
	property p_ports;
		port0_oe_n_out == 8'hFF && port6_low_out == 4'h0 && port6_low_oe_n_out == 4'h0;
	endproperty
	a_entry: assert property (p_entry) else $error("stop not entered");
	a_halt: assert property (p_halt) else $error("clock running in stop");
	a_stay: assert property (p_stay) else $error("stop left without cause");
	a_wake: assert property (p_wake) else $error("oscillator not restarted");
	a_stab: assert property (p_stab) else $error("stabilization wait short");
	a_exit: assert property (p_exit) else $error("no interrupt vector");
	a_vec: assert property (p_vec) else $error("bad vector load");
	a_timer: assert property (p_timer) else $error("timer zero timing");
	a_ports: assert property (p_ports) else $error("port reset state");
	c_stop: cover property (in_stop_out && gate_out.osc_run);
	c_exit: cover property ($fell(in_stop_out));
	c_vec: cover property (s_fetch);
endmodule // smrc_core_monitor

bind smrc_core smrc_core_monitor mon (.clk_in, .nrst_in, .req_in, .nmi_in, .edge_select_in, .vec_data_in,
	.vec_addr_out, .vec_rd_out, .program_counter_out, .pc_load_out, .nmi_vector_out, .gate_out, .in_stop_out,
	.port0_oe_n_out, .port6_low_out, .port6_low_oe_n_out, .timer_zero_out);

/* test/smrc_pins_model.sv */
// program memory model answering the two reset vector fetches
`timescale 1ns/100ps
module smrc_pins_model
#(
	parameter logic [7:0] VEC_LO = 8'h34,
	parameter logic [7:0] VEC_HI = 8'h12
)
(
	input wire logic [15:0] vec_addr_in,
	input wire logic vec_rd_in,
	output logic [7:0] vec_data_out
);
	// unselected bus shows the inverse of the last fetched byte, not a stale match
	assign vec_data_out = !vec_rd_in ? ~VEC_HI : vec_addr_in == 16'h0000 ? VEC_LO : vec_addr_in == 16'h0001 ? VEC_HI : 8'hEE;
endmodule // smrc_pins_model

/* test/smrc_core_tb.sv */
// self-checking bench for the stop mode and reset control block
`timescale 1ns/100ps
module smrc_core_tb;
	import smrc_pkg::*;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	smrc_req_s req_in = '0;
	logic nmi_in = 1'b0;
	logic edge_select_in = 1'b1;
	logic [7:0] vec_data_in, rdata_out, port0_oe_n_out;
	logic [15:0] vec_addr_out, program_counter_out;
	logic vec_rd_out, pc_load_out, nmi_vector_out, in_stop_out, retain_out, timer_zero_out;
	logic [3:0] port6_low_out, port6_low_oe_n_out;
	smrc_gate_s gate_out;
	int errors = 0;
	int compares = 0;
	always #10 clk_in = ~clk_in;
	smrc_core uut (.clk_in, .nrst_in, .req_in, .rdata_out, .nmi_in, .edge_select_in, .vec_data_in, .vec_addr_out,
		.vec_rd_out, .program_counter_out, .pc_load_out, .nmi_vector_out, .gate_out, .in_stop_out, .retain_out,
		.port0_oe_n_out, .port6_low_out, .port6_low_oe_n_out, .timer_zero_out);
	smrc_pins_model mem (.vec_addr_in(vec_addr_out), .vec_rd_in(vec_rd_out), .vec_data_out(vec_data_in));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in) req_in <= '{1'b1, 1'b0, a, d};
		@(posedge clk_in) req_in <= '0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_in) req_in <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_in) req_in <= '0;
		@(negedge clk_in) chk({8'h00, rdata_out}, {8'h00, exp});
	endtask
	// reset held six cycles, then the vector fetch must finish in two edges
	task automatic boot();
		@(posedge clk_in) nrst_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in) chk(program_counter_out, 16'h1234);
		chk({11'h000, retain_out, pc_load_out, nmi_vector_out, in_stop_out, gate_out.cpu_run}, 16'h0019);
		chk({port0_oe_n_out, port6_low_out, port6_low_oe_n_out}, 16'hFF00);
	endtask
	task automatic complete_run();
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		// about 80000 cycles: the one stabilization wait plus a small margin
		#1600000;
		errors++;
		complete_run();
	end
	initial
	begin
		boot();
		rd(16'hFFC0, 8'h00);
		rd(16'hFFC1, 8'h00);
		wr(16'hFFC0, 8'hFD);
		rd(16'hFFC0, 8'h00);
		repeat (16) @(posedge clk_in);
		@(negedge clk_in) chk({15'h0000, timer_zero_out}, 16'h0001);
		wr(16'hFFC0, 8'h02);
		@(negedge clk_in) chk({10'h000, in_stop_out, gate_out}, 16'h0021);
		repeat (20) @(posedge clk_in);
		rd(16'hFFC0, 8'h00);
		chk({15'h0000, in_stop_out}, 16'h0001);
		@(posedge clk_in) nmi_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		nmi_in <= 1'b0;
		for (int i = 0; i < 70000 && in_stop_out; i++) @(negedge clk_in);
		chk({14'h0000, in_stop_out, nmi_vector_out}, 16'h0001);
		rd(16'hFFC0, 8'h00);
		// falling edge mode from here on, pin idles high
		@(posedge clk_in) edge_select_in <= 1'b0;
		nmi_in <= 1'b1;
		wr(16'hFFC0, 8'h02);
		repeat (10) @(posedge clk_in);
		boot();
		rd(16'hFFC0, 8'h00);
		wr(16'hFFC0, 8'h02);
		repeat (4) @(posedge clk_in);
		nmi_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		// oscillator back on, still waiting while the pin stays low
		@(negedge clk_in) chk({10'h000, in_stop_out, gate_out}, 16'h0030);
		complete_run();
	end
endmodule // smrc_core_tb
